// [rtl/vofd_config.sv]
// Input over-voltage threshold and fault-delay configuration block of a hot-swap device.
`timescale 1ns/1ps
module vofd_config #(
    // Cycles of one slow over-current step; shorten for simulation.
    parameter int OVERCURRENT_SLOW_CYCLES = vofd_pkg::OVERCURRENT_SLOW_STEP_CYCLES,
    // Cycles of one fast over-current step; shorten for simulation.
    parameter int OVERCURRENT_FAST_CYCLES = vofd_pkg::OVERCURRENT_FAST_STEP_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] cmd_code,
    input wire logic write_strobe,
    input wire logic [15:0] write_data,
    input wire logic read_strobe,
    output logic [15:0] read_data,
    output logic read_valid,
    output logic cmd_known,
    input wire logic protection_fine_resolution,
    input wire logic overcurrent_fast_resolution,
    input wire logic input_protection_enable,
    input wire logic secondary_fault_detect_enable,
    input wire logic overcurrent_protection_enable,
    input wire logic [7:0] overvoltage_fault_threshold,
    input wire logic [7:0] input_turn_on_threshold,
    input wire logic [7:0] input_turn_off_threshold,
    input wire logic [16:0] input_voltage_mv,
    input wire logic overcurrent_condition,
    input wire logic fault_good_line_n,
    output logic [8:0] protection_step_mv,
    output logic [16:0] protection_range_mv,
    output logic [16:0] turn_on_level_mv,
    output logic [16:0] turn_off_level_mv,
    output logic [16:0] overvoltage_rise_mv,
    output logic [16:0] overvoltage_fall_mv,
    output logic input_overvoltage_protection,
    output logic secondary_fault,
    output logic overcurrent_fault
);
    // Stored over-voltage configuration; only the select bit and hysteresis field exist.
    logic [15:0] input_overvoltage_config;
    // Stored fault delay configuration, with the reserved nibbles held fixed.
    logic [15:0] fault_delay_config;

    // Decoded fields of the two registers.
    logic protection_resolution_select;
    logic [2:0] overvoltage_hysteresis;
    logic [3:0] secondary_fault_delay;
    logic [3:0] overcurrent_delay;
    logic [2:0] hysteresis_steps;

    // Combinational step, range and scaled thresholds before they are registered.
    logic [8:0] next_step_mv;
    logic [16:0] next_range_mv;
    logic [7:0] fall_code;
    logic [16:0] next_turn_on_mv;
    logic [16:0] next_turn_off_mv;
    logic [16:0] next_rise_mv;
    logic [16:0] next_fall_mv;

    // Synchronised fault-good line and the two raw fault conditions.
    logic fault_good_level;
    logic secondary_condition;
    logic overcurrent_gated;
    logic [19:0] overcurrent_step_cycles;

    // Scale a threshold code by the step size and clamp it to the supported range.
    function automatic logic [16:0] scale_code(
        input logic [7:0] code,
        input logic [8:0] step_mv,
        input logic [16:0] range_mv
    );
        logic [16:0] product;
        product = 17'(code * step_mv);
        scale_code = (product > range_mv) ? range_mv : product;
    endfunction : scale_code

    // Field extraction from the stored registers.
    assign protection_resolution_select = input_overvoltage_config[vofd_pkg::OVC_SELECT_BIT];
    assign overvoltage_hysteresis =
        input_overvoltage_config[vofd_pkg::OVC_HYST_MSB:vofd_pkg::OVC_HYST_LSB];
    assign secondary_fault_delay =
        fault_delay_config[vofd_pkg::FDC_SECONDARY_MSB:vofd_pkg::FDC_SECONDARY_LSB];
    assign overcurrent_delay =
        fault_delay_config[vofd_pkg::FDC_OVERCURRENT_MSB:vofd_pkg::FDC_OVERCURRENT_LSB];

    // Register writes; reserved bits are masked so they cannot be set by software.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            input_overvoltage_config <= vofd_pkg::OVC_RESET;
            fault_delay_config <= vofd_pkg::FDC_RESET;
        end else if (write_strobe) begin
            if (cmd_code == vofd_pkg::CMD_INPUT_OVERVOLTAGE_CONFIG) begin
                input_overvoltage_config <= write_data & vofd_pkg::OVC_WRITE_MASK;
            end
            if (cmd_code == vofd_pkg::CMD_FAULT_DELAY_CONFIG) begin
                fault_delay_config <= (write_data & vofd_pkg::FDC_WRITE_MASK)
                    | vofd_pkg::FDC_FIXED_BITS;
            end
        end
    end

    // Register reads answer one cycle after the strobe; unknown codes read as zero.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            read_data <= 16'h0000;
            read_valid <= 1'b0;
            cmd_known <= 1'b0;
        end else begin
            read_valid <= read_strobe;
            if (read_strobe) begin
                if (cmd_code == vofd_pkg::CMD_INPUT_OVERVOLTAGE_CONFIG) begin
                    read_data <= input_overvoltage_config & vofd_pkg::OVC_WRITE_MASK;
                    cmd_known <= 1'b1;
                end else if (cmd_code == vofd_pkg::CMD_FAULT_DELAY_CONFIG) begin
                    read_data <= fault_delay_config;
                    cmd_known <= 1'b1;
                end else begin
                    read_data <= 16'h0000;
                    cmd_known <= 1'b0;
                end
            end
        end
    end

    // Pick the step size: the fine bit wins, otherwise the select bit chooses.
    always_comb begin
        if (protection_fine_resolution) begin
            next_step_mv = vofd_pkg::RES_FINE_MV;
            next_range_mv = vofd_pkg::RANGE_FINE_MV;
        end else if (protection_resolution_select) begin
            next_step_mv = vofd_pkg::RES_MEDIUM_MV;
            next_range_mv = vofd_pkg::RANGE_MEDIUM_MV;
        end else begin
            next_step_mv = vofd_pkg::RES_COARSE_MV;
            next_range_mv = vofd_pkg::RANGE_COARSE_MV;
        end
    end

    // Hysteresis decode; codes 3 and 4 both give four steps, 5 and 6 give two.
    always_comb begin
        unique case (overvoltage_hysteresis)
            3'h0: hysteresis_steps = 3'd7;
            3'h1: hysteresis_steps = 3'd6;
            3'h2: hysteresis_steps = 3'd5;
            3'h3: hysteresis_steps = 3'd4;
            3'h4: hysteresis_steps = 3'd4;
            3'h5: hysteresis_steps = 3'd2;
            3'h6: hysteresis_steps = 3'd2;
            3'h7: hysteresis_steps = 3'd0;
        endcase
    end

    // The falling code floors at zero so a small limit cannot wrap to a huge threshold.
    always_comb begin
        if (overvoltage_fault_threshold > {5'h00, hysteresis_steps}) begin
            fall_code = overvoltage_fault_threshold - {5'h00, hysteresis_steps};
        end else begin
            fall_code = 8'h00;
        end
    end

    // All three input thresholds share one step size.
    assign next_turn_on_mv = scale_code(input_turn_on_threshold, next_step_mv, next_range_mv);
    assign next_turn_off_mv = scale_code(input_turn_off_threshold, next_step_mv, next_range_mv);
    assign next_rise_mv = scale_code(overvoltage_fault_threshold, next_step_mv, next_range_mv);
    assign next_fall_mv = scale_code(fall_code, next_step_mv, next_range_mv);

    // Register the derived levels so downstream comparators see stable values.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            protection_step_mv <= 9'h000;
            protection_range_mv <= 17'h0_0000;
            turn_on_level_mv <= 17'h0_0000;
            turn_off_level_mv <= 17'h0_0000;
            overvoltage_rise_mv <= 17'h0_0000;
            overvoltage_fall_mv <= 17'h0_0000;
        end else begin
            protection_step_mv <= next_step_mv;
            protection_range_mv <= next_range_mv;
            turn_on_level_mv <= next_turn_on_mv;
            turn_off_level_mv <= next_turn_off_mv;
            overvoltage_rise_mv <= next_rise_mv;
            overvoltage_fall_mv <= next_fall_mv;
        end
    end

    // Over-voltage latch: trips at the rising level and releases below the falling one.
    // Disabling input protection drops it at once rather than waiting for hysteresis.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            input_overvoltage_protection <= 1'b0;
        end else if (!input_protection_enable) begin
            input_overvoltage_protection <= 1'b0;
        end else if (input_voltage_mv >= overvoltage_rise_mv) begin
            input_overvoltage_protection <= 1'b1;
        end else if (input_voltage_mv < overvoltage_fall_mv) begin
            input_overvoltage_protection <= 1'b0;
        end
    end

    // The fault-good pin comes from outside the clock domain.
    vofd_pin_sync u_fault_good_sync (
        .clock(clock),
        .reset_n(reset_n),
        .pin(fault_good_line_n),
        .level(fault_good_level)
    );

    // A low line counts only while detection is enabled.
    assign secondary_condition = secondary_fault_detect_enable && !fault_good_level;
    assign overcurrent_gated = overcurrent_protection_enable && overcurrent_condition;

    // Over-current step length follows the external resolution bit.
    assign overcurrent_step_cycles = overcurrent_fast_resolution
        ? 20'(OVERCURRENT_FAST_CYCLES) : 20'(OVERCURRENT_SLOW_CYCLES);

    // Secondary fault qualified by 1 us steps.
    vofd_fault_timer u_secondary_timer (
        .clock(clock),
        .reset_n(reset_n),
        .condition(secondary_condition),
        .delay_steps(secondary_fault_delay),
        .step_cycles(20'(vofd_pkg::SECONDARY_STEP_CYCLES)),
        .fault(secondary_fault)
    );

    // Total over-current fault qualified by 500 or 100 us steps.
    vofd_fault_timer u_overcurrent_timer (
        .clock(clock),
        .reset_n(reset_n),
        .condition(overcurrent_gated),
        .delay_steps(overcurrent_delay),
        .step_cycles(overcurrent_step_cycles),
        .fault(overcurrent_fault)
    );
endmodule : vofd_config

// [rtl/vofd_fault_timer.sv]
// Qualification timer that declares a fault after a condition persists for a programmed delay.
`timescale 1ns/1ps
module vofd_fault_timer (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic condition,
    input wire logic [3:0] delay_steps,
    input wire logic [19:0] step_cycles,
    output logic fault
);
    // Cycle count inside one step and the number of whole steps elapsed.
    logic [19:0] cycle_count;
    logic [3:0] step_count;
    logic expired;

    // The delay has run out once the elapsed steps reach the programmed count.
    assign expired = (step_count >= delay_steps);

    // Count while the condition holds; any gap restarts the delay from zero.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cycle_count <= 20'h0_0000;
            step_count <= 4'h0;
        end else if (!condition) begin
            cycle_count <= 20'h0_0000;
            step_count <= 4'h0;
        end else if (!expired) begin
            if (cycle_count >= step_cycles - 20'h0_0001) begin
                cycle_count <= 20'h0_0000;
                step_count <= step_count + 4'h1;
            end else begin
                cycle_count <= cycle_count + 20'h0_0001;
            end
        end
    end

    // The fault stands while the condition persists past the delay; a zero delay is immediate.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fault <= 1'b0;
        end else begin
            fault <= condition && expired;
        end
    end
endmodule : vofd_fault_timer

// [rtl/vofd_pin_sync.sv]
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module vofd_pin_sync (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic pin,
    output logic level
);
    // Stage one is only read by stage two, to keep metastability contained.
    logic stage_one;
    logic stage_two;
    logic stage_three;

    // Shift the pin through three flip-flops; the idle pin level is high.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage_one <= 1'b1;
            stage_two <= 1'b1;
            stage_three <= 1'b1;
        end else begin
            stage_one <= pin;
            stage_two <= stage_one;
            stage_three <= stage_two;
        end
    end

    // The settled level moves only when the two late stages agree, rejecting one-cycle glitches.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            level <= 1'b1;
        end else if (stage_two == stage_three) begin
            level <= stage_three;
        end
    end
endmodule : vofd_pin_sync

// [rtl/vofd_pkg.sv]
// Package of command codes, field layouts, reset values and timing counts for the block.
package vofd_pkg;
    // Command codes of the two configuration registers.
    localparam logic [7:0] CMD_INPUT_OVERVOLTAGE_CONFIG = 8'hE7;
    localparam logic [7:0] CMD_FAULT_DELAY_CONFIG = 8'hE8;

    // Writable bits of the over-voltage configuration register; the rest read as zero.
    localparam logic [15:0] OVC_WRITE_MASK = 16'h00F0;
    localparam logic [15:0] OVC_RESET = 16'h0000;
    localparam int OVC_SELECT_BIT = 7;
    localparam int OVC_HYST_LSB = 4;
    localparam int OVC_HYST_MSB = 6;

    // Fault delay register: two 4-bit delay fields, reserved nibbles fixed at five.
    localparam logic [15:0] FDC_WRITE_MASK = 16'h0F0F;
    localparam logic [15:0] FDC_FIXED_BITS = 16'h5050;
    localparam logic [15:0] FDC_RESET = 16'h5050;
    localparam int FDC_SECONDARY_LSB = 8;
    localparam int FDC_SECONDARY_MSB = 11;
    localparam int FDC_OVERCURRENT_LSB = 0;
    localparam int FDC_OVERCURRENT_MSB = 3;

    // Protection step sizes and the ranges they support, in millivolts.
    localparam logic [8:0] RES_COARSE_MV = 9'd500;
    localparam logic [8:0] RES_MEDIUM_MV = 9'd250;
    localparam logic [8:0] RES_FINE_MV = 9'd125;
    localparam logic [16:0] RANGE_COARSE_MV = 17'd64000;
    localparam logic [16:0] RANGE_MEDIUM_MV = 17'd32000;
    localparam logic [16:0] RANGE_FINE_MV = 17'd16000;

    // Clock and delay step sizes.
    localparam int CLOCK_KHZ = 50000;
    localparam int SECONDARY_STEP_NS = 1000;
    localparam int SECONDARY_STEP_CYCLES = SECONDARY_STEP_NS * CLOCK_KHZ / 1000000;
    localparam int OVERCURRENT_SLOW_STEP_US = 500;
    localparam int OVERCURRENT_FAST_STEP_US = 100;
    localparam int OVERCURRENT_SLOW_STEP_CYCLES = OVERCURRENT_SLOW_STEP_US * CLOCK_KHZ / 1000;
    localparam int OVERCURRENT_FAST_STEP_CYCLES = OVERCURRENT_FAST_STEP_US * CLOCK_KHZ / 1000;
    localparam int STEP_COUNT_WIDTH = 20;
endpackage : vofd_pkg

// [verif/tb_vofd_config.sv]
// Self-checking testbench of the over-voltage and fault-delay configuration block.
`timescale 1ns/1ps
module tb_vofd_config;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] cmd_code, overvoltage_fault_threshold = 0, input_turn_on_threshold = 0;
    logic [7:0] input_turn_off_threshold = 0;
    logic write_strobe, read_strobe, read_valid, cmd_known;
    logic [15:0] write_data, read_data;
    logic protection_fine_resolution = 0, overcurrent_fast_resolution = 0;
    logic input_protection_enable = 0, secondary_fault_detect_enable = 0;
    logic overcurrent_protection_enable = 0, overcurrent_condition = 0, fault_good_line_n = 1;
    logic [16:0] input_voltage_mv = 0, protection_range_mv, turn_on_level_mv, turn_off_level_mv;
    logic [16:0] overvoltage_rise_mv, overvoltage_fall_mv;
    logic [8:0] protection_step_mv;
    logic input_overvoltage_protection, secondary_fault, overcurrent_fault;
    logic [16:0] notes[$]; // Expected {cmd_known, read_data} of each pending read.
    int seed = 5605; // Fixed seed keeps every run identical.
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    // Hysteresis in steps for each code; codes 3 to 6 follow the designer's reading.
    int hyst_lsb [8] = '{7, 6, 5, 4, 4, 2, 2, 0};

    always #10 clock = ~clock; // 50 MHz.

    vofd_config #(.OVERCURRENT_SLOW_CYCLES(10), .OVERCURRENT_FAST_CYCLES(4)) dut (.*);
    vofd_host host (.*);

    task stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task compare(input logic [16:0] got, input logic [16:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare

    // Cut a hang short; the whole run needs fewer than a thousand cycles.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    // Read answers stand one cycle, so they are taken mid-cycle against the oldest note.
    always @(negedge clock) begin
        if (read_valid === 1'b1)
            compare({cmd_known, read_data}, notes.size() ? notes.pop_front() : 17'h1_ffff);
    end

    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    task settle;
        cyc(3);
        @(negedge clock);
    endtask : settle

    task rd(input logic [7:0] code, input logic [16:0] exp);
        notes.push_back(exp);
        host.read_reg(code);
    endtask : rd

    // Level of a threshold code, clamped to the range of the selected step.
    function automatic logic [16:0] lvl(input int code, input int step);
        int v;
        v = code * step;
        return 17'((v > step * 128) ? step * 128 : v);
    endfunction : lvl

    initial begin
        int i;
        int step;
        int f;
        logic [15:0] junk;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        rd(8'hE7, 17'h1_0000);
        rd(8'hE8, 17'h1_5050);
        rd(8'hE9, 17'h0_0000);
        host.write_reg(8'hE7, 16'hFFFF);
        rd(8'hE7, 17'h1_00F0);
        // Every select, resolution and hysteresis code, with random threshold codes; the fault code is 3 while i is below 4.
        for (i = 0; i < 32; i++) begin
            junk = 16'($random(seed));
            host.write_reg(8'hE7, {junk[15:8], i[0], i[4:2], junk[3:0]});
            rd(8'hE7, {9'h100, i[0], i[4:2], 4'h0});
            @(posedge clock);
            protection_fine_resolution <= i[1];
            input_turn_on_threshold <= 8'($random(seed));
            input_turn_off_threshold <= 8'($random(seed));
            overvoltage_fault_threshold <= (i < 4) ? 8'd3 : 8'($random(seed));
            settle();
            step = i[1] ? 125 : (i[0] ? 250 : 500);
            f = overvoltage_fault_threshold - hyst_lsb[i[4:2]];
            compare(17'(protection_step_mv), 17'(step));
            compare(protection_range_mv, 17'(step * 128));
            compare(turn_on_level_mv, lvl(input_turn_on_threshold, step));
            compare(turn_off_level_mv, lvl(input_turn_off_threshold, step));
            compare(overvoltage_rise_mv, lvl(overvoltage_fault_threshold, step));
            compare(overvoltage_fall_mv, lvl((f < 0) ? 0 : f, step));
        end
        // Rising level 20000 mV, falling level (40 - 7) x 500 = 16500 mV.
        host.write_reg(8'hE7, 16'h0000);
        @(posedge clock);
        protection_fine_resolution <= 1'b0;
        overvoltage_fault_threshold <= 8'd40;
        input_voltage_mv <= 17'd20000;
        input_protection_enable <= 1'b1;
        settle();
        compare(17'(input_overvoltage_protection), 17'd1);
        input_voltage_mv <= 17'd16600;
        settle();
        compare(17'(input_overvoltage_protection), 17'd1);
        input_voltage_mv <= 17'd16400;
        settle();
        compare(17'(input_overvoltage_protection), 17'd0);
        // Secondary delay 2 x 50 cycles, over-current delay 3 steps.
        host.write_reg(8'hE8, 16'h0203);
        rd(8'hE8, 17'h1_5253);
        @(posedge clock);
        secondary_fault_detect_enable <= 1'b1;
        fault_good_line_n <= 1'b0;
        cyc(95);
        @(negedge clock);
        compare(17'(secondary_fault), 17'd0);
        cyc(15);
        @(negedge clock);
        compare(17'(secondary_fault), 17'd1);
        fault_good_line_n <= 1'b1;
        // The pin synchroniser needs four edges before the timer sees the line released.
        cyc(6);
        @(negedge clock);
        compare(17'(secondary_fault), 17'd0);
        fault_good_line_n <= 1'b0;
        cyc(60);
        fault_good_line_n <= 1'b1;
        cyc(2);
        fault_good_line_n <= 1'b0;
        cyc(95);
        @(negedge clock);
        compare(17'(secondary_fault), 17'd0);
        cyc(15);
        @(negedge clock);
        compare(17'(secondary_fault), 17'd1);
        secondary_fault_detect_enable <= 1'b0;
        settle();
        compare(17'(secondary_fault), 17'd0);
        // Over-current at both step sizes: 3 x 10 and 3 x 4 cycles.
        for (i = 0; i < 2; i++) begin
            @(posedge clock);
            overcurrent_fast_resolution <= i[0];
            overcurrent_protection_enable <= 1'b1;
            overcurrent_condition <= 1'b1;
            cyc(i ? 9 : 27);
            @(negedge clock);
            compare(17'(overcurrent_fault), 17'd0);
            cyc(6);
            @(negedge clock);
            compare(17'(overcurrent_fault), 17'd1);
            overcurrent_condition <= 1'b0;
            settle();
            compare(17'(overcurrent_fault), 17'd0);
        end
        cyc(5);
        stop_test();
    end
endmodule : tb_vofd_config

// [verif/vofd_config_chk.sv]
// Concurrent checks on the ports of the configuration block.
`timescale 1ns/1ps
module vofd_config_chk (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] cmd_code,
    input wire logic read_strobe,
    input wire logic [15:0] read_data,
    input wire logic read_valid,
    input wire logic cmd_known,
    input wire logic protection_fine_resolution,
    input wire logic input_protection_enable,
    input wire logic secondary_fault_detect_enable,
    input wire logic overcurrent_protection_enable,
    input wire logic overcurrent_condition,
    input wire logic [8:0] protection_step_mv,
    input wire logic [16:0] protection_range_mv,
    input wire logic [16:0] turn_on_level_mv,
    input wire logic [16:0] overvoltage_rise_mv,
    input wire logic [16:0] overvoltage_fall_mv,
    input wire logic input_overvoltage_protection,
    input wire logic secondary_fault,
    input wire logic overcurrent_fault
);
    // All checks share the one clock and the asynchronous reset.
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    // The answer to a read comes exactly one cycle after the request.
    chk_read_answer: assert property (read_strobe |=> read_valid)
        else $error("read answer missing");
    chk_read_spurious: assert property (!read_strobe |=> !read_valid)
        else $error("read answer without request");
    // Reserved bits of the over-voltage register read as zero.
    chk_reserved_zero: assert property ($past(read_strobe) && $past(cmd_code) == 8'hE7
        |-> read_data[15:8] == 8'h00 && read_data[3:0] == 4'h0) else $error("reserved bits set");
    // Fixed nibbles of the delay register read as five.
    chk_fixed_nibbles: assert property ($past(read_strobe) && $past(cmd_code) == 8'hE8
        |-> read_data[15:12] == 4'h5 && read_data[7:4] == 4'h5) else $error("fixed nibble wrong");
    // Fine resolution overrides the select bit.
    chk_fine_step: assert property ($past(reset_n) && $past(protection_fine_resolution)
        |-> protection_step_mv == 9'd125) else $error("fine step wrong");
    // The fine and coarse step sizes each pair with their own range.
    chk_range_pair: assert property ((protection_step_mv != 9'd125 || protection_range_mv == 17'd16000)
        && (protection_step_mv != 9'd500 || protection_range_mv == 17'd64000)) else $error("range wrong");
    chk_clamp_range: assert property (turn_on_level_mv <= protection_range_mv)
        else $error("turn-on level above range");
    chk_fall_order: assert property (overvoltage_fall_mv <= overvoltage_rise_mv)
        else $error("falling level above rising level");
    chk_ovp_gated: assert property (!input_protection_enable |=> !input_overvoltage_protection)
        else $error("over-voltage while disabled");
    chk_sec_gated: assert property (!secondary_fault_detect_enable |=> !secondary_fault)
        else $error("secondary fault while disabled");
    // Dropping the over-current condition clears the fault on the next cycle.
    chk_oc_restart: assert property (!(overcurrent_condition && overcurrent_protection_enable)
        |=> !overcurrent_fault) else $error("over-current fault without condition");
endmodule : vofd_config_chk

bind vofd_config vofd_config_chk u_chk (.clock, .reset_n, .cmd_code, .read_strobe, .read_data,
    .read_valid, .cmd_known, .protection_fine_resolution, .input_protection_enable,
    .secondary_fault_detect_enable, .overcurrent_protection_enable, .overcurrent_condition,
    .protection_step_mv, .protection_range_mv, .turn_on_level_mv, .overvoltage_rise_mv,
    .overvoltage_fall_mv, .input_overvoltage_protection, .secondary_fault, .overcurrent_fault);

// [verif/vofd_host.sv]
// Management host model that issues command-port writes and reads to the block.
`timescale 1ns/1ps
module vofd_host (
    input wire logic clock,
    output logic [7:0] cmd_code,
    output logic write_strobe,
    output logic [15:0] write_data,
    output logic read_strobe
);
    // Idle state at time zero: no strobe and no live command on the port.
    initial begin
        cmd_code = 8'h00;
        write_strobe = 1'b0;
        write_data = 16'h0000;
        read_strobe = 1'b0;
    end

    // One-cycle write; code and data are inverted afterwards so stale values never look valid.
    task write_reg(input logic [7:0] code, input logic [15:0] data);
        @(posedge clock);
        cmd_code <= code;
        write_data <= data;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        cmd_code <= ~code;
        write_data <= ~data;
    endtask : write_reg

    // One-cycle read request; the answer is collected by the bench monitor.
    task read_reg(input logic [7:0] code);
        @(posedge clock);
        cmd_code <= code;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        cmd_code <= ~code;
    endtask : read_reg
endmodule : vofd_host
